// >>> src/osc_pkg.sv
// Purpose: Shared constants and types of the phase accumulator oscillator
// Assumes: Registers sit in the low byte of aligned 32-bit Wishbone words
// Notes: Offsets are byte addresses
`default_nettype none
package osc_pkg;
    // Register byte offsets
    localparam logic [5:0] OFF_CONTROL = 6'h00;
    localparam logic [5:0] OFF_CLOCK_CONTROL = 6'h04;
    localparam logic [5:0] OFF_ACC_LOW = 6'h08;
    localparam logic [5:0] OFF_ACC_HIGH = 6'h0C;
    localparam logic [5:0] OFF_ACC_UPPER = 6'h10;
    localparam logic [5:0] OFF_INC_LOW = 6'h14;
    localparam logic [5:0] OFF_INC_HIGH = 6'h18;
    localparam logic [5:0] OFF_IRQ_STATUS = 6'h1C;
    localparam logic [5:0] OFF_IRQ_MASK = 6'h20;

    // Control register fields
    localparam int BIT_ENABLE = 7;
    localparam int BIT_PIN_ENABLE = 6;
    localparam int BIT_OUT_LEVEL = 5;
    localparam int BIT_POLARITY = 4;
    localparam int BIT_PULSE_MODE = 0;

    // Clock control fields
    localparam int PWS_LSB = 5;
    localparam int CKS_LSB = 0;

    // Status and mask field
    localparam int BIT_OVERFLOW = 0;

    // Widths
    localparam int ACC_W = 20;
    localparam int INC_W = 16;

    // Reset values
    localparam logic [15:0] INC_RESET = 16'h0001;
    localparam logic [19:0] ACC_RESET = 20'h00000;
    localparam logic [7:0] REG_RESET = 8'h00;

    typedef enum logic [1:0] {
        CKS_EXT_PIN = 2'h0,
        CKS_SYSTEM = 2'h1,
        CKS_FAST_OSC = 2'h2,
        CKS_LOGIC_CELL = 2'h3
    } clock_source_e;
endpackage
`default_nettype wire

// >>> src/osc_tick_if.sv
// Purpose: Carries the clock source choice and the resulting tick
// Assumes: Single system clock
// Notes: tick is a one-cycle pulse per rising edge of the chosen source
`default_nettype none
interface osc_tick_if;
    logic [1:0] clock_source_select;
    logic tick;
    modport source (input clock_source_select, output tick);
    modport user (output clock_source_select, input tick);
endinterface
`default_nettype wire

// >>> src/osc_tick_gen.sv
// Purpose: Turns the selected oscillator clock source into tick pulses
// Assumes: Source inputs are synchronous to clk_i
// Notes: System clock source ticks on every cycle
`default_nettype none
module osc_tick_gen (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Clock sources
    input wire logic external_clock_pin_i,
    input wire logic internal_fast_oscillator_i,
    input wire logic logic_cell_output_i,
    // Link to the core
    osc_tick_if.source tick_if
);
    typedef struct packed {
        logic ext_prev;
        logic fast_prev;
        logic cell_prev;
    } tick_state_s;

    tick_state_s st_ff;
    tick_state_s nxt_st;

    always_comb begin
        nxt_st.ext_prev = external_clock_pin_i;
        nxt_st.fast_prev = internal_fast_oscillator_i;
        nxt_st.cell_prev = logic_cell_output_i;
    end

    // Rising edge of the chosen source
    always_comb begin
        case (tick_if.clock_source_select)  // [RULE2]
            osc_pkg::CKS_EXT_PIN: tick_if.tick = external_clock_pin_i & ~st_ff.ext_prev;
            osc_pkg::CKS_SYSTEM: tick_if.tick = 1'b1;
            osc_pkg::CKS_FAST_OSC: tick_if.tick = internal_fast_oscillator_i & ~st_ff.fast_prev;
            osc_pkg::CKS_LOGIC_CELL: tick_if.tick = logic_cell_output_i & ~st_ff.cell_prev;
            default: tick_if.tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '{ext_prev: 1'b0, fast_prev: 1'b0, cell_prev: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule
`default_nettype wire

// >>> src/osc_top.sv
// Purpose: Phase accumulator oscillator with Wishbone register access
// Assumes: All inputs synchronous to clk_i; registers in low data byte
// Notes: Operation
// Operation
// RULE1: pulse width code n gives 2**n oscillator clock periods
// RULE2: clock source select 00 pin, 01 system, 10 fast osc, 11 logic cell
// RULE3: pulse width only matters in pulse mode, ignored in fixed duty mode
// RULE4: software keeps pulse width shorter than overflow period
// RULE5: accumulator bits 7..0 readable and writable as low byte
// RULE6: accumulator bits 15..8 readable and writable as high byte
// RULE7: accumulator bits 19..16 in upper byte low nibble, rest reads zero
// RULE8: increment low byte read/write, resets to 01
// RULE9: increment high byte read/write, resets to zero
// RULE10: reset clears control and accumulator; clock control bits 4..2 read zero
// RULE11: fixed duty mode toggles output on each overflow
// RULE12: pulse mode drives output active from edge after overflow for set width
// RULE13: increment double-buffered; immediate when disabled, else after low write
// RULE14: overflow sets a sticky flag that stays until software clears it
// RULE15: enabled accumulator adds buffered increment per tick; bit 19 carry overflows
// RULE16: register writes reach accumulator and buffer aligned to oscillator ticks; accumulator byte writes here apply in the bus write cycle
//
// Design decisions made here: the register offsets and the Wishbone register port.
`default_nettype none
module osc_top #(
    parameter int ACC_WIDTH = osc_pkg::ACC_W,
    parameter int INC_WIDTH = osc_pkg::INC_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Oscillator clock sources
    input wire logic external_clock_pin_i,
    input wire logic internal_fast_oscillator_i,
    input wire logic logic_cell_output_i,
    // Output stage
    output logic output_level_o,
    output logic output_pin_o,
    output logic output_pin_oe_o,
    // Interrupt
    output logic irq_o
);
    typedef struct packed {
        logic oscillator_enable;
        logic output_pin_enable;
        logic output_polarity;
        logic pulse_mode_select;
        logic [2:0] pulse_width_select;
        logic [1:0] clock_source_select;
        logic [ACC_WIDTH-1:0] phase_accumulator;
        logic [INC_WIDTH-1:0] phase_increment;
        logic [INC_WIDTH-1:0] increment_buffer;
        logic load_pending;
        logic raw_out;
        logic [7:0] pulse_count;
        logic overflow_flag;
        logic overflow_interrupt_enable;
        logic ack;
        logic [31:0] rdata;
        logic level;
        logic pin;
        logic pin_oe;
        logic irq;
    } osc_state_s;

    osc_state_s st_ff;
    osc_state_s nxt_st;
    logic [ACC_WIDTH:0] sum;
    logic overflow;
    logic take;
    logic wr;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic tick;

    osc_tick_if tick_bus ();

    assign tick_bus.clock_source_select = st_ff.clock_source_select;  // [RULE2]
    assign tick = tick_bus.tick;

    osc_tick_gen u_tick_gen (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .external_clock_pin_i(external_clock_pin_i),
        .internal_fast_oscillator_i(internal_fast_oscillator_i),
        .logic_cell_output_i(logic_cell_output_i),
        .tick_if(tick_bus)
    );

    assign take = cyc_i & stb_i & ~st_ff.ack;
    assign wr = take & we_i & sel_i[0];
    assign wbyte = dat_i[7:0];
    // Carry out of the top bit marks overflow
    assign sum = {1'b0, st_ff.phase_accumulator}
        + {{(ACC_WIDTH + 1 - INC_WIDTH){1'b0}}, st_ff.increment_buffer};  // [RULE15]
    assign overflow = st_ff.oscillator_enable & tick & sum[ACC_WIDTH];  // [RULE15]

    // Read mux
    always_comb begin
        rbyte = 8'h00;
        case (adr_i)
            osc_pkg::OFF_CONTROL: begin
                rbyte[osc_pkg::BIT_ENABLE] = st_ff.oscillator_enable;
                rbyte[osc_pkg::BIT_PIN_ENABLE] = st_ff.output_pin_enable;
                rbyte[osc_pkg::BIT_OUT_LEVEL] = st_ff.level;
                rbyte[osc_pkg::BIT_POLARITY] = st_ff.output_polarity;
                rbyte[osc_pkg::BIT_PULSE_MODE] = st_ff.pulse_mode_select;
            end
            osc_pkg::OFF_CLOCK_CONTROL: begin
                rbyte[osc_pkg::PWS_LSB +: 3] = st_ff.pulse_width_select;
                rbyte[osc_pkg::CKS_LSB +: 2] = st_ff.clock_source_select;  // [RULE10]
            end
            osc_pkg::OFF_ACC_LOW: rbyte = st_ff.phase_accumulator[7:0];  // [RULE5]
            osc_pkg::OFF_ACC_HIGH: rbyte = st_ff.phase_accumulator[15:8];  // [RULE6]
            osc_pkg::OFF_ACC_UPPER: rbyte = {4'h0, st_ff.phase_accumulator[19:16]};  // [RULE7]
            osc_pkg::OFF_INC_LOW: rbyte = st_ff.phase_increment[7:0];  // [RULE8]
            osc_pkg::OFF_INC_HIGH: rbyte = st_ff.phase_increment[15:8];  // [RULE9]
            osc_pkg::OFF_IRQ_STATUS: rbyte[osc_pkg::BIT_OVERFLOW] = st_ff.overflow_flag;
            osc_pkg::OFF_IRQ_MASK: rbyte[osc_pkg::BIT_OVERFLOW] = st_ff.overflow_interrupt_enable;
            default: rbyte = 8'h00;
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = take;
        nxt_st.rdata = (take & ~we_i) ? {24'h000000, rbyte} : 32'h00000000;

        // Accumulation and output generation, one step per tick
        if (st_ff.oscillator_enable && tick) begin
            nxt_st.phase_accumulator = sum[ACC_WIDTH-1:0];  // [RULE15]
            if (st_ff.load_pending) begin
                nxt_st.increment_buffer = st_ff.phase_increment;  // [RULE13] [RULE16]
                nxt_st.load_pending = 1'b0;
            end
            if (st_ff.pulse_mode_select) begin
                if (overflow) begin
                    nxt_st.raw_out = 1'b1;  // [RULE12]
                    // Width 2**n, counted down to zero
                    nxt_st.pulse_count = 8'((9'h001 << st_ff.pulse_width_select) - 9'h001);  // [RULE1]
                end else if (st_ff.raw_out) begin
                    if (st_ff.pulse_count == 8'h00) begin
                        nxt_st.raw_out = 1'b0;  // [RULE12] [RULE3]
                    end else begin
                        nxt_st.pulse_count = st_ff.pulse_count - 8'h01;
                    end
                end
            end else if (overflow) begin
                nxt_st.raw_out = ~st_ff.raw_out;  // [RULE11] [RULE3]
            end
        end

        // Disabled: buffer follows the visible increment at once
        if (!st_ff.oscillator_enable) begin
            nxt_st.increment_buffer = st_ff.phase_increment;  // [RULE13]
            nxt_st.load_pending = 1'b0;
        end

        // Register writes; software write to the accumulator wins over a tick
        if (wr) begin
            case (adr_i)
                osc_pkg::OFF_CONTROL: begin
                    nxt_st.oscillator_enable = wbyte[osc_pkg::BIT_ENABLE];
                    nxt_st.output_pin_enable = wbyte[osc_pkg::BIT_PIN_ENABLE];
                    nxt_st.output_polarity = wbyte[osc_pkg::BIT_POLARITY];
                    nxt_st.pulse_mode_select = wbyte[osc_pkg::BIT_PULSE_MODE];
                end
                osc_pkg::OFF_CLOCK_CONTROL: begin
                    nxt_st.pulse_width_select = wbyte[osc_pkg::PWS_LSB +: 3];
                    nxt_st.clock_source_select = wbyte[osc_pkg::CKS_LSB +: 2];
                end
                osc_pkg::OFF_ACC_LOW: nxt_st.phase_accumulator[7:0] = wbyte;  // [RULE5]
                osc_pkg::OFF_ACC_HIGH: nxt_st.phase_accumulator[15:8] = wbyte;  // [RULE6]
                osc_pkg::OFF_ACC_UPPER: nxt_st.phase_accumulator[19:16] = wbyte[3:0];  // [RULE7]
                osc_pkg::OFF_INC_LOW: begin
                    nxt_st.phase_increment[7:0] = wbyte;  // [RULE8]
                    // High byte must already be written
                    nxt_st.load_pending = st_ff.oscillator_enable;  // [RULE13]
                end
                osc_pkg::OFF_INC_HIGH: nxt_st.phase_increment[15:8] = wbyte;  // [RULE9]
                osc_pkg::OFF_IRQ_MASK: begin
                    nxt_st.overflow_interrupt_enable = wbyte[osc_pkg::BIT_OVERFLOW];
                end
                default: nxt_st.load_pending = nxt_st.load_pending;
            endcase
        end

        // Sticky flag: write one clears, a same-cycle overflow wins
        if (wr && adr_i == osc_pkg::OFF_IRQ_STATUS && wbyte[osc_pkg::BIT_OVERFLOW]) begin
            nxt_st.overflow_flag = 1'b0;
        end
        if (overflow) begin
            nxt_st.overflow_flag = 1'b1;  // [RULE14]
        end

        // Registered output stage; polarity 1 means active low
        nxt_st.level = nxt_st.raw_out ^ nxt_st.output_polarity;
        nxt_st.pin = nxt_st.level;
        nxt_st.pin_oe = nxt_st.oscillator_enable & nxt_st.output_pin_enable;
        nxt_st.irq = nxt_st.overflow_flag & nxt_st.overflow_interrupt_enable;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '{
                oscillator_enable: 1'b0,
                output_pin_enable: 1'b0,
                output_polarity: 1'b0,
                pulse_mode_select: 1'b0,
                pulse_width_select: 3'h0,
                clock_source_select: 2'h0,
                phase_accumulator: osc_pkg::ACC_RESET,
                phase_increment: osc_pkg::INC_RESET,
                increment_buffer: osc_pkg::INC_RESET,
                load_pending: 1'b0,
                raw_out: 1'b0,
                pulse_count: osc_pkg::REG_RESET,
                overflow_flag: 1'b0,
                overflow_interrupt_enable: 1'b0,
                ack: 1'b0,
                rdata: 32'h00000000,
                level: 1'b0,
                pin: 1'b0,
                pin_oe: 1'b0,
                irq: 1'b0
            };  // [RULE10]
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dat_o = st_ff.rdata;
    assign ack_o = st_ff.ack;
    assign output_level_o = st_ff.level;
    assign output_pin_o = st_ff.pin;
    assign output_pin_oe_o = st_ff.pin_oe;
    assign irq_o = st_ff.irq;
endmodule
`default_nettype wire

// >>> bench/osc_props.sv
// Purpose: Port-level properties of the oscillator block
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to osc_top after the module
`default_nettype none
module osc_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Outputs
    input wire logic output_level_o,
    input wire logic output_pin_o,
    input wire logic output_pin_oe_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing after request");
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_data_idle_zero: assert property ((!ack_o || we_i) |-> dat_o == 32'h0)
        else $error("read data outside read ack");
    a_upper_nibble_zero: assert property (
        ack_o && !we_i && adr_i == osc_pkg::OFF_ACC_UPPER |-> dat_o[31:4] == 28'h0)
        else $error("upper byte high bits set");
    a_clock_gaps_zero: assert property (
        ack_o && !we_i && adr_i == osc_pkg::OFF_CLOCK_CONTROL |-> dat_o[4:2] == 3'h0)
        else $error("clock control gap bits set");
    a_reset_clears_all: assert property (
        disable iff (1'b0) rst_i |=> !ack_o && !irq_o && !output_level_o && !output_pin_oe_o)
        else $error("outputs not cleared");
    a_pin_tracks_level: assert property (output_pin_o == output_level_o)
        else $error("pin differs from level");
    // Flag is sticky, so the interrupt may only drop after a register write
    a_irq_stays_set: assert property (irq_o && !(cyc_i && stb_i && we_i) |=> irq_o)
        else $error("interrupt dropped by itself");
endmodule
bind osc_top osc_props i_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .output_level_o(output_level_o),
    .output_pin_o(output_pin_o), .output_pin_oe_o(output_pin_oe_o), .irq_o(irq_o));
`default_nettype wire

// >>> bench/tb.sv
// Purpose: Register-level tests of the oscillator block
// Assumes: One bus request at a time
// Notes: Clock sources are pulsed by hand so ticks can be counted exactly
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [5:0] adr_i = 6'h00;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] q;
    logic ack_o, output_level_o, output_pin_o, output_pin_oe_o, irq_o;
    logic [2:0] src = 3'h0;
    int failures = 0;
    int comparisons = 0;
    int n;
    // Increment high byte sits ahead of the low byte, as software must write it
    logic [5:0] ra [10] = '{osc_pkg::OFF_CONTROL, osc_pkg::OFF_CLOCK_CONTROL,
        osc_pkg::OFF_ACC_LOW, osc_pkg::OFF_ACC_HIGH, osc_pkg::OFF_ACC_UPPER, osc_pkg::OFF_INC_HIGH,
        osc_pkg::OFF_INC_LOW, osc_pkg::OFF_IRQ_STATUS, osc_pkg::OFF_IRQ_MASK, 6'h24};
    logic [7:0] wd [10] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'hFF, 8'h34, 8'h12, 8'h00, 8'h01, 8'h77};
    logic [7:0] rx [10] = '{8'h00, 8'hE3, 8'hA5, 8'h5A, 8'h0F, 8'h34, 8'h12, 8'h00, 8'h01, 8'h00};

    osc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .external_clock_pin_i(src[0]), .internal_fast_oscillator_i(src[1]),
        .logic_cell_output_i(src[2]), .output_level_o(output_level_o),
        .output_pin_o(output_pin_o), .output_pin_oe_o(output_pin_oe_o), .irq_o(irq_o));

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Request is held until ack is sampled, then one idle cycle follows
    // No limit on the wait: a hang is ended by the watchdog
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic chk(input logic [5:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        cmp("register read", {24'h0, e}, q);
    endtask

    task automatic pulse(input logic [2:0] m);
        src <= m;
        repeat (2) @(posedge clk_i);
        src <= 3'h0;
        repeat (2) @(posedge clk_i);
    endtask

    // Counts the cycles of the next complete high phase of the output
    task automatic width(output int w);
        int t;
        for (t = 0; t < 300 && output_level_o !== 1'b0; t++) @(posedge clk_i);
        for (t = 0; t < 300 && output_level_o !== 1'b1; t++) @(posedge clk_i);
        for (w = 0; w < 300 && output_level_o === 1'b1; w++) @(posedge clk_i);
    endtask

    // Tests need well under 2000 cycles
    initial begin
        repeat (4000) @(posedge clk_i);
        failures++;
        test_done();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 10; i++) chk(ra[i], (i == 6) ? 8'h01 : 8'h00);
        for (int i = 0; i < 10; i++) wb(1'b1, ra[i], wd[i]);
        for (int i = 0; i < 10; i++) chk(ra[i], rx[i]);
        wb(1'b1, osc_pkg::OFF_INC_HIGH, 8'h00);
        wb(1'b1, osc_pkg::OFF_INC_LOW, 8'h05);
        wb(1'b1, osc_pkg::OFF_ACC_HIGH, 8'h00);
        wb(1'b1, osc_pkg::OFF_ACC_UPPER, 8'h00);
        // Unselected sources pulse only alongside the selected one, so three pulses count three ticks
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, osc_pkg::OFF_ACC_LOW, 8'h00);
            wb(1'b1, osc_pkg::OFF_CLOCK_CONTROL, (i == 0) ? 8'h00 : 8'(i + 1));
            wb(1'b1, osc_pkg::OFF_CONTROL, 8'h80);
            pulse(3'h7);
            pulse(3'h7);
            pulse(3'(1 << i));
            wb(1'b1, osc_pkg::OFF_CONTROL, 8'h00);
            chk(osc_pkg::OFF_ACC_LOW, 8'h0F);
        end
        wb(1'b1, osc_pkg::OFF_INC_HIGH, 8'h80);
        wb(1'b1, osc_pkg::OFF_INC_LOW, 8'h00);
        wb(1'b1, osc_pkg::OFF_ACC_LOW, 8'h00);
        wb(1'b1, osc_pkg::OFF_CLOCK_CONTROL, 8'hE1);
        wb(1'b1, osc_pkg::OFF_CONTROL, 8'hC0);
        width(n);
        cmp("fixed duty half period", 32, n);
        cmp("pin enable", 1'b1, output_pin_oe_o);
        cmp("interrupt", 1'b1, irq_o);
        chk(osc_pkg::OFF_IRQ_STATUS, 8'h01);
        wb(1'b1, osc_pkg::OFF_INC_HIGH, 8'h40);
        wb(1'b1, osc_pkg::OFF_INC_LOW, 8'h00);
        width(n);
        cmp("reloaded half period", 64, n);
        // Widths stay below the overflow period
        wb(1'b1, osc_pkg::OFF_CONTROL, 8'hC1);
        for (int p = 0; p < 5; p++) begin
            wb(1'b1, osc_pkg::OFF_CLOCK_CONTROL, {3'(p), 5'h01});
            width(n);
            cmp("pulse width", 1 << p, n);
        end
        // Active low: the high phase is the 64-tick period less the 16-tick pulse
        wb(1'b1, osc_pkg::OFF_CONTROL, 8'hD1);
        width(n);
        cmp("inverted pulse gap", 48, n);
        wb(1'b1, osc_pkg::OFF_CONTROL, 8'h00);
        wb(1'b1, osc_pkg::OFF_IRQ_STATUS, 8'h01);
        chk(osc_pkg::OFF_IRQ_STATUS, 8'h00);
        cmp("interrupt cleared", 1'b0, irq_o);
        // Reset again with mask, clock control and increment registers dirty
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 10; i++) chk(ra[i], (i == 6) ? 8'h01 : 8'h00);
        test_done();
    end
endmodule
`default_nettype wire
